// ---- rtl/gpef_pkg.sv ----
// package: constants and state type of the two shared gpio ports
package gpef_pkg;

    // ------------------------------------------------------------
    // port widths
    // ------------------------------------------------------------
    localparam int GPEF_WIDE_W = 8;
    localparam int GPEF_NARROW_W = 6;
    localparam int GPEF_DATA_W = 32;
    localparam int GPEF_ADDR_W = 8;

    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [5:0] GPEF_IDX_WIDE_LATCH = 6'h08;
    localparam logic [5:0] GPEF_IDX_NARROW_LATCH = 6'h09;
    localparam logic [5:0] GPEF_IDX_WIDE_DIR = 6'h0C;
    localparam logic [5:0] GPEF_IDX_NARROW_DIR = 6'h0D;
    localparam int GPEF_IDX_LSB = 2;

    // ------------------------------------------------------------
    // reset values and default sharing masks
    // ------------------------------------------------------------
    localparam logic [7:0] GPEF_WIDE_DIR_RST = 8'h00;
    localparam logic [5:0] GPEF_NARROW_DIR_RST = 6'h00;
    localparam logic [7:0] GPEF_WIDE_TMR_MASK = 8'h1F;
    localparam logic [7:0] GPEF_WIDE_SER_MASK = 8'h60;
    localparam logic [5:0] GPEF_NARROW_SPI_MASK = 6'h0F;
    localparam logic [5:0] GPEF_NARROW_SER_MASK = 6'h30;
    localparam logic [31:0] GPEF_UNMAPPED_RD = 32'h00000000;

    // ------------------------------------------------------------
    // whole state of the port block
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] wlat;
        logic [7:0] wdir;
        logic [7:0] ws1;
        logic [7:0] ws2;
        logic [7:0] ws3;
        logic [7:0] wpin;
        logic [7:0] wout;
        logic [7:0] woe;
        logic [5:0] nlat;
        logic [5:0] ndir;
        logic [5:0] ns1;
        logic [5:0] ns2;
        logic [5:0] ns3;
        logic [5:0] npin;
        logic [5:0] nout;
        logic [5:0] noe;
        logic [31:0] rdata;
        logic wait_r;
    } gpef_state_s;

endpackage : gpef_pkg

// ---- rtl/gpef_ports.sv ----
// module: two shared gpio ports with an avalon-mm register slave
//
// Behaviour
// - eight writable readable latch bits, wide port
// - wide direction one drives pin, zero floats
// - reset clears all wide direction bits
// - wide read: latch if output, pin if input
// - data writes with byte lane 0 enabled update the latch
// - writing input-pin latch leaves read pin unchanged
// - reset leaves both data latches untouched
// - timer-owned wide pins take timer direction
// - direction bit still selects readback source
// - wide port: five timer, two serial pins
// - six latch bits for narrow port
// - narrow direction one drives pin, zero floats
// - reset clears all narrow direction bits
// - narrow read: latch if output, pin if input
// - spi or serial owns narrow pin direction
// - narrow direction still selects readback source
// - narrow port: four spi, two serial pins
`timescale 1ns/100ps

module gpef_ports
    import gpef_pkg::*;
#(
    parameter logic [7:0] P_WIDE_TMR_MASK = GPEF_WIDE_TMR_MASK,
    parameter logic [7:0] P_WIDE_SER_MASK = GPEF_WIDE_SER_MASK,
    parameter logic [5:0] P_NARROW_SPI_MASK = GPEF_NARROW_SPI_MASK,
    parameter logic [5:0] P_NARROW_SER_MASK = GPEF_NARROW_SER_MASK
)
(
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [7:0] i_wide_pin,
    output logic [7:0] o_wide_pin,
    output logic [7:0] o_wide_pin_oe,
    input wire logic [7:0] i_wide_tmr_own,
    input wire logic [7:0] i_wide_tmr_out,
    input wire logic [7:0] i_wide_tmr_oe,
    input wire logic [7:0] i_wide_ser_own,
    input wire logic [7:0] i_wide_ser_out,
    input wire logic [7:0] i_wide_ser_oe,
    output logic [7:0] o_wide_pin_level,
    input wire logic [5:0] i_narrow_pin,
    output logic [5:0] o_narrow_pin,
    output logic [5:0] o_narrow_pin_oe,
    input wire logic [5:0] i_narrow_spi_own,
    input wire logic [5:0] i_narrow_spi_out,
    input wire logic [5:0] i_narrow_spi_oe,
    input wire logic [5:0] i_narrow_ser_own,
    input wire logic [5:0] i_narrow_ser_out,
    input wire logic [5:0] i_narrow_ser_oe,
    output logic [5:0] o_narrow_pin_level
);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------

    // peripheral a wins over b, else the port's own value
    function automatic logic [7:0] gpef_pick(
        input logic [7:0] own_a,
        input logic [7:0] val_a,
        input logic [7:0] own_b,
        input logic [7:0] val_b,
        input logic [7:0] dflt
    );
        gpef_pick = (own_a & val_a) | (~own_a & own_b & val_b)
            | (~own_a & ~own_b & dflt);
    endfunction : gpef_pick

    // readback: latch for output bits, pin for input bits
    function automatic logic [7:0] gpef_rdmix(
        input logic [7:0] lat,
        input logic [7:0] dir,
        input logic [7:0] pin
    );
        gpef_rdmix = (lat & dir) | (pin & ~dir);
    endfunction : gpef_rdmix

    // a bit follows its synchroniser only once stages 2 and 3 agree
    function automatic logic [7:0] gpef_filt(
        input logic [7:0] s2,
        input logic [7:0] s3,
        input logic [7:0] held
    );
        gpef_filt = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & held);
    endfunction : gpef_filt

    // ------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------
    gpef_state_s st_reg;
    gpef_state_s st_next;
    logic [7:0] wide_own_t;
    logic [7:0] wide_own_s;
    logic [7:0] nar_own_a;
    logic [7:0] nar_own_b;
    logic [5:0] bus_idx;
    logic bus_req;
    logic bus_commit;
    logic wr_lane0;

    // sharing masks limit which pins each peripheral may claim
    assign wide_own_t = i_wide_tmr_own & P_WIDE_TMR_MASK;
    assign wide_own_s = i_wide_ser_own & P_WIDE_SER_MASK;
    assign nar_own_a = {2'h0, i_narrow_spi_own & P_NARROW_SPI_MASK};
    assign nar_own_b = {2'h0, i_narrow_ser_own & P_NARROW_SER_MASK};

    // bus commits only in the cycle waitrequest is seen low
    assign bus_idx = i_avs_address[GPEF_ADDR_W-1:GPEF_IDX_LSB];
    assign bus_req = i_avs_read | i_avs_write;
    assign bus_commit = bus_req & ~st_reg.wait_r;
    assign wr_lane0 = i_avs_write & bus_commit & i_avs_byteenable[0];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------

    // one wait cycle per access keeps readdata registered
    always_comb
    begin
        logic [7:0] nlat8;
        logic [7:0] ndir8;
        logic [7:0] npin8;
        nlat8 = {2'h0, st_reg.nlat};
        ndir8 = {2'h0, st_reg.ndir};
        npin8 = {2'h0, st_reg.npin};
        st_next = st_reg;
        // three-stage pin sampling; stage 1 feeds only stage 2
        st_next.ws1 = i_wide_pin;
        st_next.ws2 = st_reg.ws1;
        st_next.ws3 = st_reg.ws2;
        st_next.wpin = gpef_filt(st_reg.ws2, st_reg.ws3, st_reg.wpin);
        st_next.ns1 = i_narrow_pin;
        st_next.ns2 = st_reg.ns1;
        st_next.ns3 = st_reg.ns2;
        st_next.npin = 6'(gpef_filt({2'h0, st_reg.ns2},
            {2'h0, st_reg.ns3}, npin8));
        // latch writes ignore direction; pins keep being sampled
        if (wr_lane0 && bus_idx == GPEF_IDX_WIDE_LATCH)
        begin
            st_next.wlat = i_avs_writedata[7:0];
        end
        if (wr_lane0 && bus_idx == GPEF_IDX_NARROW_LATCH)
        begin
            st_next.nlat = i_avs_writedata[5:0];
        end
        if (wr_lane0 && bus_idx == GPEF_IDX_WIDE_DIR)
        begin
            st_next.wdir = i_avs_writedata[7:0];
        end
        if (wr_lane0 && bus_idx == GPEF_IDX_NARROW_DIR)
        begin
            st_next.ndir = i_avs_writedata[5:0];
        end
        // pin drive: owner peripheral first, else latch and direction
        st_next.wout = gpef_pick(wide_own_t, i_wide_tmr_out,
            wide_own_s, i_wide_ser_out,
            st_reg.wlat & st_reg.wdir);
        st_next.woe = gpef_pick(wide_own_t, i_wide_tmr_oe,
            wide_own_s, i_wide_ser_oe, st_reg.wdir);
        st_next.nout = 6'(gpef_pick(nar_own_a, {2'h0, i_narrow_spi_out},
            nar_own_b, {2'h0, i_narrow_ser_out}, nlat8 & ndir8));
        st_next.noe = 6'(gpef_pick(nar_own_a, {2'h0, i_narrow_spi_oe},
            nar_own_b, {2'h0, i_narrow_ser_oe}, ndir8));
        // handshake: drop waitrequest for one cycle, then raise again
        if (st_reg.wait_r && bus_req)
        begin
            st_next.wait_r = 1'b0;
            case (bus_idx)
                GPEF_IDX_WIDE_LATCH:
                    st_next.rdata = {24'h000000, gpef_rdmix(st_reg.wlat,
                        st_reg.wdir, st_reg.wpin)};
                GPEF_IDX_NARROW_LATCH:
                    st_next.rdata = {24'h000000, gpef_rdmix(nlat8,
                        ndir8, npin8)};
                GPEF_IDX_WIDE_DIR:
                    st_next.rdata = {24'h000000, st_reg.wdir};
                GPEF_IDX_NARROW_DIR:
                    st_next.rdata = {26'h0000000, st_reg.ndir};
                default:
                    st_next.rdata = GPEF_UNMAPPED_RD;
            endcase
        end
        else
        begin
            st_next.wait_r = 1'b1;
        end
        // reset clears direction and bus state but not the latches
        if (i_srst)
        begin
            st_next.wdir = GPEF_WIDE_DIR_RST;
            st_next.ndir = GPEF_NARROW_DIR_RST;
            st_next.ws1 = 8'h00;
            st_next.ws2 = 8'h00;
            st_next.ws3 = 8'h00;
            st_next.wpin = 8'h00;
            st_next.ns1 = 6'h00;
            st_next.ns2 = 6'h00;
            st_next.ns3 = 6'h00;
            st_next.npin = 6'h00;
            st_next.wout = 8'h00;
            st_next.woe = 8'h00;
            st_next.nout = 6'h00;
            st_next.noe = 6'h00;
            st_next.rdata = 32'h00000000;
            st_next.wait_r = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------

    // reset acts even while the clock enable is low
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst || i_ce)
        begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign o_avs_readdata = st_reg.rdata;
    assign o_avs_waitrequest = st_reg.wait_r;
    assign o_wide_pin = st_reg.wout;
    assign o_wide_pin_oe = st_reg.woe;
    assign o_wide_pin_level = st_reg.wpin;
    assign o_narrow_pin = st_reg.nout;
    assign o_narrow_pin_oe = st_reg.noe;
    assign o_narrow_pin_level = st_reg.npin;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);

    AST_WDIR_RESET: assert property (
        $past(i_srst) |-> st_reg.wdir == 8'h00)
        else $error("wide direction not cleared by reset");

    AST_NDIR_RESET: assert property (
        $past(i_srst) |-> st_reg.ndir == 6'h00)
        else $error("narrow direction not cleared by reset");

    // latches are unknown until first written, so compare by stability
    AST_LATCH_KEEP: assert property (
        $past(i_srst) |-> $stable(st_reg.wlat) && $stable(st_reg.nlat))
        else $error("reset changed a data latch");

    // the edge after reset is skipped: reset forces drive and enables low
    // even on pins that a peripheral still claims
    AST_WOE_DIR: assert property (
        $past(i_ce) && !$past(i_srst)
        |-> (o_wide_pin_oe & ~$past(wide_own_t | wide_own_s))
            == ($past(st_reg.wdir) & ~$past(wide_own_t | wide_own_s)))
        else $error("wide enable does not follow direction");

    AST_NOE_DIR: assert property (
        $past(i_ce) && !$past(i_srst)
        |-> (8'(o_narrow_pin_oe) & ~$past(nar_own_a | nar_own_b))
            == (8'($past(st_reg.ndir)) & ~$past(nar_own_a | nar_own_b)))
        else $error("narrow enable does not follow direction");

    AST_TMR_OWNS: assert property (
        $past(i_ce) && !$past(i_srst)
        |-> (o_wide_pin_oe & $past(wide_own_t))
            == ($past(i_wide_tmr_oe) & $past(wide_own_t)))
        else $error("timer-owned pin ignores timer enable");

    AST_SPI_OWNS: assert property (
        $past(i_ce) && !$past(i_srst)
        |-> (8'(o_narrow_pin_oe) & $past(nar_own_a))
            == (8'($past(i_narrow_spi_oe)) & $past(nar_own_a)))
        else $error("spi-owned pin ignores spi enable");

    AST_PERIPH_VAL: assert property (
        $past(i_ce) && !$past(i_srst)
        |-> (o_wide_pin & $past(wide_own_t))
            == ($past(i_wide_tmr_out) & $past(wide_own_t)))
        else $error("timer-owned pin ignores timer value");

    AST_WIDE_RD: assert property (
        ($past(i_ce) && $fell(o_avs_waitrequest) && i_avs_read
            && bus_idx == GPEF_IDX_WIDE_LATCH)
        |-> o_avs_readdata == {24'h000000, $past((st_reg.wlat
            & st_reg.wdir) | (st_reg.wpin & ~st_reg.wdir))})
        else $error("wide readback source wrong");

    AST_NAR_RD: assert property (
        ($past(i_ce) && $fell(o_avs_waitrequest) && i_avs_read
            && bus_idx == GPEF_IDX_NARROW_LATCH)
        |-> o_avs_readdata[5:0] == $past((st_reg.nlat & st_reg.ndir)
            | (st_reg.npin & ~st_reg.ndir)))
        else $error("narrow readback source wrong");

    AST_LATCH_WR: assert property (
        (i_ce && wr_lane0 && bus_idx == GPEF_IDX_WIDE_LATCH)
        |=> st_reg.wlat == $past(i_avs_writedata[7:0]))
        else $error("wide latch write lost");

    AST_NLAT_WR: assert property (
        (i_ce && wr_lane0 && bus_idx == GPEF_IDX_NARROW_LATCH)
        |=> st_reg.nlat == $past(i_avs_writedata[5:0]))
        else $error("narrow latch write lost");

    AST_SPI_VAL: assert property (
        $past(i_ce) && !$past(i_srst)
        |-> (8'(o_narrow_pin) & $past(nar_own_a))
            == (8'($past(i_narrow_spi_out)) & $past(nar_own_a)))
        else $error("spi-owned pin ignores spi value");

    AST_INPUT_STAYS: assert property (
        (i_ce && wr_lane0 && bus_idx == GPEF_IDX_WIDE_LATCH
            && (wide_own_t | wide_own_s) == 8'h00 && st_reg.wdir == 8'h00)
        |=> o_wide_pin_oe == 8'h00)
        else $error("latch write to input pin drove it");

    AST_WAIT_ONE: assert property (
        (i_ce && !o_avs_waitrequest) |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    COV_WIDE_READ: cover property (
        i_avs_read && !o_avs_waitrequest
            && bus_idx == GPEF_IDX_WIDE_LATCH);
    COV_NAR_WRITE: cover property (
        wr_lane0 && bus_idx == GPEF_IDX_NARROW_LATCH);
    COV_TMR_OWN: cover property (wide_own_t != 8'h00 && st_reg.wdir != 8'h00);
    COV_SPI_OWN: cover property (nar_own_a != 8'h00);
    COV_CE_HOLD: cover property (!i_ce && o_wide_pin_oe != 8'h00);

endmodule : gpef_ports

// ---- tb/gpef_pin_model.sv ----
// partner model: outside pin drivers resolved against the port buffers
`timescale 1ns/100ps

module gpef_pin_model
(
    input wire logic [7:0] i_wide_drv,
    input wire logic [7:0] i_wide_oe,
    input wire logic [7:0] i_wide_ext,
    output logic [7:0] o_wide_lvl,
    input wire logic [5:0] i_narrow_drv,
    input wire logic [5:0] i_narrow_oe,
    input wire logic [5:0] i_narrow_ext,
    output logic [5:0] o_narrow_lvl
);
    // a pin whose buffer is off shows the outside driver, never a held value
    assign o_wide_lvl = (i_wide_oe & i_wide_drv) | (~i_wide_oe & i_wide_ext);
    assign o_narrow_lvl = (i_narrow_oe & i_narrow_drv)
        | (~i_narrow_oe & i_narrow_ext);
endmodule : gpef_pin_model

// ---- tb/gpef_ports_tb_top.sv ----
// testbench: random and corner traffic on both shared gpio ports
`timescale 1ns/100ps

module gpef_ports_tb_top
    import gpef_pkg::*;
;
    logic clk_sys = 1'b0, srst = 1'b1, ce = 1'b1, rd = 1'b0, wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [3:0] be = 4'hF;
    logic wreq;
    logic [7:0] w_ext = 8'h00, w_lvl, w_out, w_oe, ew_out, ew_oe;
    logic [7:0] t_own = 8'h00, t_out = 8'h00, t_oe = 8'h00;
    logic [7:0] s_own = 8'h00, s_out = 8'h00, s_oe = 8'h00;
    logic [5:0] n_ext = 6'h00, n_lvl, n_out, n_oe, en_out, en_oe;
    logic [5:0] p_own = 6'h00, p_out = 6'h00, p_oe = 6'h00;
    logic [5:0] q_own = 6'h00, q_out = 6'h00, q_oe = 6'h00;
    logic [7:0] lat_w, dir_w, w_plv;
    logic [5:0] lat_n, dir_n, n_plv;
    int err_total = 0;
    int checked = 0;

    // free-running system clock, 4 ns period
    always #2 clk_sys = ~clk_sys;

    gpef_ports u_gpef_ports (.i_clk_sys(clk_sys), .i_srst(srst), .i_ce(ce),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_wide_pin(w_lvl), .o_wide_pin(w_out), .o_wide_pin_oe(w_oe),
        .i_wide_tmr_own(t_own), .i_wide_tmr_out(t_out), .i_wide_tmr_oe(t_oe),
        .i_wide_ser_own(s_own), .i_wide_ser_out(s_out), .i_wide_ser_oe(s_oe),
        .o_wide_pin_level(w_plv), .i_narrow_pin(n_lvl), .o_narrow_pin(n_out),
        .o_narrow_pin_oe(n_oe), .i_narrow_spi_own(p_own),
        .i_narrow_spi_out(p_out), .i_narrow_spi_oe(p_oe),
        .i_narrow_ser_own(q_own), .i_narrow_ser_out(q_out),
        .i_narrow_ser_oe(q_oe), .o_narrow_pin_level(n_plv));

    gpef_pin_model u_gpef_pin_model (.i_wide_drv(w_out), .i_wide_oe(w_oe),
        .i_wide_ext(w_ext), .o_wide_lvl(w_lvl), .i_narrow_drv(n_out),
        .i_narrow_oe(n_oe), .i_narrow_ext(n_ext), .o_narrow_lvl(n_lvl));

    // ------------------------------------------------------------
    // shared tasks and expectation functions
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one avalon access; held until waitrequest is sampled low
    // no local limit: only the watchdog may end a hung wait
    task automatic bus(input logic is_wr, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] b, output logic [31:0] q);
        rd <= ~is_wr;
        wr <= is_wr;
        addr <= a;
        wdata <= d;
        be <= b;
        do
        begin
            @(posedge clk_sys);
        end
        while (wreq !== 1'b0);
        q = rdata;
        check("bus_ack", {31'h0, wreq}, 32'h0);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_sys);
    endtask : bus

    // owner one beats owner two; unowned pins fall back to the port value
    function automatic logic [7:0] drv(input logic [7:0] dflt, o1, v1, o2,
        v2);
        return (o1 & v1) | (~o1 & o2 & v2) | (~o1 & ~o2 & dflt);
    endfunction : drv

    task automatic final_report();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hD2EC));
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        bus(1'b0, 8'h30, 32'h0, 4'hF, rv);
        check("wide_dir_rst", rv, 32'h0);
        bus(1'b0, 8'h34, 32'h0, 4'hF, rv);
        check("narrow_dir_rst", rv, 32'h0);
        check("wide_oe_rst", {24'h0, w_oe}, 32'h0);
        // first two passes are all-output and all-input corners
        for (int i = 0; i < 40; i++)
        begin
            lat_w = 8'($urandom);
            lat_n = 6'($urandom);
            dir_w = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            dir_n = (i == 0) ? 6'h3F : (i == 1) ? 6'h00 : 6'($urandom);
            w_ext <= 8'($urandom);
            n_ext <= 6'($urandom);
            {t_own, t_out, t_oe, s_own, s_out, s_oe} <= 48'($urandom)
                ^ {$urandom, 16'h0};
            {p_own, p_out, p_oe, q_own, q_out, q_oe} <= 36'($urandom)
                ^ {$urandom, 4'h0};
            // latch before direction so a new output starts clean
            bus(1'b1, 8'h20, {24'h0, lat_w}, 4'h1, rv);
            bus(1'b1, 8'h24, {26'h0, lat_n}, 4'h1, rv);
            bus(1'b1, 8'h30, {24'h0, dir_w}, 4'h1, rv);
            bus(1'b1, 8'h34, {26'h0, dir_n}, 4'h1, rv);
            // settle pin output and the four-edge input filter
            repeat (8) @(posedge clk_sys);
            ew_oe = drv(dir_w, t_own & GPEF_WIDE_TMR_MASK, t_oe,
                s_own & GPEF_WIDE_SER_MASK, s_oe);
            ew_out = drv(lat_w & dir_w, t_own & GPEF_WIDE_TMR_MASK, t_out,
                s_own & GPEF_WIDE_SER_MASK, s_out);
            en_oe = 6'(drv({2'h0, dir_n}, {2'h0, p_own & GPEF_NARROW_SPI_MASK},
                {2'h0, p_oe}, {2'h0, q_own & GPEF_NARROW_SER_MASK},
                {2'h0, q_oe}));
            en_out = 6'(drv({2'h0, lat_n & dir_n},
                {2'h0, p_own & GPEF_NARROW_SPI_MASK}, {2'h0, p_out},
                {2'h0, q_own & GPEF_NARROW_SER_MASK}, {2'h0, q_out}));
            check("wide_oe", {24'h0, w_oe}, {24'h0, ew_oe});
            check("wide_out", {24'h0, w_out}, {24'h0, ew_out});
            check("narrow_oe", {26'h0, n_oe}, {26'h0, en_oe});
            check("narrow_out", {26'h0, n_out}, {26'h0, en_out});
            check("wide_level", {24'h0, w_plv}, {24'h0, (ew_oe & ew_out)
                | (~ew_oe & w_ext)});
            check("narrow_level", {26'h0, n_plv}, {26'h0, (en_oe & en_out)
                | (~en_oe & n_ext)});
            bus(1'b0, 8'h20, 32'h0, 4'hF, rv);
            check("wide_read", rv, {24'h0, (dir_w & lat_w) | (~dir_w & ((ew_oe
                & ew_out) | (~ew_oe & w_ext)))});
            bus(1'b0, 8'h24, 32'h0, 4'hF, rv);
            check("narrow_read", rv, {26'h0, (dir_n & lat_n) | (~dir_n & ((en_oe
                & en_out) | (~en_oe & n_ext)))});
        end
        // disabled lane and unmapped places must leave registers alone
        bus(1'b1, 8'h30, 32'hFF, 4'h1, rv);
        bus(1'b1, 8'h20, {24'h0, ~lat_w}, 4'hE, rv);
        bus(1'b1, 8'h38, 32'h0, 4'hF, rv);
        bus(1'b0, 8'h3C, 32'h0, 4'hF, rv);
        check("unmapped_read", rv, GPEF_UNMAPPED_RD);
        bus(1'b0, 8'h20, 32'h0, 4'hF, rv);
        check("wide_be_off", rv, {24'h0, lat_w});
        // second reset mid-run: directions clear, latches survive
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        bus(1'b0, 8'h30, 32'h0, 4'hF, rv);
        check("wide_dir_rst2", rv, 32'h0);
        bus(1'b1, 8'h30, 32'hFF, 4'h1, rv);
        bus(1'b1, 8'h34, 32'h3F, 4'h1, rv);
        bus(1'b0, 8'h20, 32'h0, 4'hF, rv);
        check("wide_lat_kept", rv, {24'h0, lat_w});
        bus(1'b0, 8'h24, 32'h0, 4'hF, rv);
        check("narrow_lat_kept", rv, {26'h0, lat_n});
        // a low clock enable freezes pin drive while ownership moves
        ew_oe = drv(8'hFF, t_own & GPEF_WIDE_TMR_MASK, t_oe,
            s_own & GPEF_WIDE_SER_MASK, s_oe);
        ew_out = drv(lat_w, t_own & GPEF_WIDE_TMR_MASK, t_out,
            s_own & GPEF_WIDE_SER_MASK, s_out);
        ce <= 1'b0;
        t_own <= 8'h00;
        s_own <= 8'h00;
        repeat (6) @(posedge clk_sys);
        check("ce_frozen_oe", {24'h0, w_oe}, {24'h0, ew_oe});
        check("ce_frozen_out", {24'h0, w_out}, {24'h0, ew_out});
        ce <= 1'b1;
        // input pin: a latch write must neither drive nor show on readback
        bus(1'b1, 8'h30, 32'h0, 4'h1, rv);
        bus(1'b1, 8'h20, {24'h0, ~lat_w}, 4'h1, rv);
        repeat (6) @(posedge clk_sys);
        check("input_oe", {24'h0, w_oe}, 32'h0);
        bus(1'b0, 8'h20, 32'h0, 4'hF, rv);
        check("input_read", rv, {24'h0, w_ext});
        final_report();
    end

    // watchdog: the whole run needs about 1100 cycles
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        err_total++;
        $display("[FAIL] watchdog expected done seen hang");
        final_report();
    end
endmodule : gpef_ports_tb_top
